//--- rtl/addr_recog_pkg.sv
// Constants for the receive address-recognition table access block.
// Assumes a 16-bit asynchronous handshake bus and a single core clock.

package addr_recog_pkg;

   // ------------------------------------------------------------
   // Table layout
   // ------------------------------------------------------------
   localparam logic [11:0] STATION_MATCH_ENTRY_FIRST_OFF = 12'ha00;
   localparam logic [11:0] STATION_MATCH_ENTRY_SECOND_OFF = 12'ha08;
   localparam logic [11:0] HASH_MASK_BYTE_ZERO_OFF = 12'hbf0;
   localparam logic [11:0] HASH_MASK_BYTE_SEVEN_OFF = 12'hbfb;
   localparam logic [2:0] TABLE_REGION = 3'h5;
   localparam int ENTRY_BITS = 48;
   localparam int MAX_ENTRIES = 64;
   localparam int HASH_ENTRIES = 2;
   localparam logic [1:0] WORD_LAST = 2'h2;
   localparam logic [1:0] WORD_UNUSED = 2'h3;
   localparam int SYNC_STAGES = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic ACK_N_RESET = 1'h1;
   localparam logic [15:0] RD_DATA_RESET = 16'h0000;
   localparam logic [5:0] INDEX_RESET = 6'h00;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h1,
      ST_ACK = 2'h2
   } bus_state_t;

endpackage : addr_recog_pkg

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is a level that is stable long enough to be sampled.
`timescale 1ns/1ps

module pin_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   if (WIDTH < 1)
   begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = d_in;
      sync_d = meta_q;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end
      else if (ce_in)
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_out = sync_q;

endmodule : pin_sync

//--- rtl/addr_recog_table.sv
// Address-recognition table: bus slave access path plus match lookup.
// Assumes bus pins arrive asynchronously; config and compare inputs are core-clock logic.
`timescale 1ns/1ps

module addr_recog_table
#(
   parameter int ENTRIES = addr_recog_pkg::MAX_ENTRIES
)
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [23:12] module_base_address_in,
   input wire logic hash_enable_in,
   input wire logic [23:1] bus_addr_in,
   input wire logic bus_a0_in,
   input wire logic bus_as_n_in,
   input wire logic bus_uds_n_in,
   input wire logic bus_lds_n_in,
   input wire logic bus_rw_in,
   input wire logic bus_byte_mode_in,
   input wire logic [15:0] bus_data_in,
   output logic [15:0] bus_data_out,
   output logic bus_data_oe_out,
   output logic transfer_acknowledge_n_out,
   output logic transfer_acknowledge_oe_out,
   input wire logic cmp_valid_in,
   input wire logic [47:0] cmp_addr_in,
   input wire logic [5:0] cmp_crc_top_in,
   output logic match_done_out,
   output logic match_perfect_out,
   output logic match_hash_out,
   output logic [5:0] match_index_out
);

   // Entry index is six bits and the last two entries double as the mask
   if (ENTRIES < addr_recog_pkg::HASH_ENTRIES + 1 || ENTRIES > addr_recog_pkg::MAX_ENTRIES)
   begin : g_bad_entries
      $error("ENTRIES out of range");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [44:0] pins_sync;
   logic s_as_n;
   logic s_uds_n;
   logic s_lds_n;
   logic s_rw;
   logic s_byte;
   logic [23:0] s_addr;
   logic [15:0] s_data;

   pin_sync #(.WIDTH(45), .RESET_VAL({3'h7, 42'h0})) u_pin_sync
   (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .d_in({bus_as_n_in, bus_uds_n_in, bus_lds_n_in, bus_rw_in, bus_byte_mode_in,
             bus_addr_in, bus_a0_in, bus_data_in}),
      .q_out(pins_sync)
   );

   assign {s_as_n, s_uds_n, s_lds_n, s_rw, s_byte, s_addr, s_data} = pins_sync;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [47:0] mem_q [ENTRIES];
   logic [47:0] mem_d [ENTRIES];
   logic [ENTRIES-1:0] valid_q;
   logic [ENTRIES-1:0] valid_d;
   addr_recog_pkg::bus_state_t st_q;
   addr_recog_pkg::bus_state_t st_d;
   logic ack_n_q;
   logic ack_n_d;
   logic ack_oe_q;
   logic ack_oe_d;
   logic [15:0] rd_q;
   logic [15:0] rd_d;
   logic rd_oe_q;
   logic rd_oe_d;
   logic done_q;
   logic done_d;
   logic perf_q;
   logic perf_d;
   logic hash_q;
   logic hash_d;
   logic [5:0] idx_q;
   logic [5:0] idx_d;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic loc_ok(input logic [5:0] ent, input logic [1:0] wrd, input logic hash);
      loc_ok = (int'(ent) < ENTRIES) && (wrd != addr_recog_pkg::WORD_UNUSED) &&
               !(hash && int'(ent) >= ENTRIES - addr_recog_pkg::HASH_ENTRIES &&
                 wrd == addr_recog_pkg::WORD_LAST);
   endfunction : loc_ok

   // Mask byte k lives in entry ENTRIES-2 (bytes 0..3) or ENTRIES-1 (bytes 4..7)
   function automatic logic mask_bit(input logic [5:0] h);
      logic [2:0] k;
      k = 3'h7 - h[5:3];
      mask_bit = k[2] ? mem_q[ENTRIES-1][{k[1:0], h[2:0]}] : mem_q[ENTRIES-2][{k[1:0], h[2:0]}];
   endfunction : mask_bit

   logic [5:0] ent;
   logic [1:0] wrd;
   logic hit;
   logic req;
   logic go_ok;
   logic prot;
   logic we_even;
   logic we_odd;
   logic wr_b5;
   logic [7:0] wr_odd;
   logic [7:0] rd_even;
   logic [7:0] rd_odd;
   logic [7:0] rd_sel;
   logic perf_hit;
   logic [5:0] perf_idx;
   logic hash_hit;

   always_comb
   begin
      ent = s_addr[8:3];
      wrd = s_addr[2:1];
      hit = (s_addr[23:12] == module_base_address_in) && (s_addr[11:9] == addr_recog_pkg::TABLE_REGION);
      req = !s_as_n && (!s_uds_n || !s_lds_n);
      go_ok = ce_in && st_q == addr_recog_pkg::ST_IDLE && req && hit && loc_ok(ent, wrd, hash_enable_in);
      prot = hash_enable_in && int'(ent) >= ENTRIES - addr_recog_pkg::HASH_ENTRIES;
      we_even = !s_rw && (s_byte ? !s_addr[0] : !s_uds_n);
      we_odd = !s_rw && (s_byte ? s_addr[0] : !s_lds_n);
      wr_odd = s_byte ? s_data[15:8] : s_data[7:0];
      wr_b5 = we_odd && wrd == addr_recog_pkg::WORD_LAST;
      rd_even = 8'h00;
      rd_odd = 8'h00;
      if (int'(ent) < ENTRIES)
      begin
         rd_even = mem_q[ent][{wrd, 4'h0} +: 8];
         rd_odd = mem_q[ent][{wrd, 4'h8} +: 8];
      end
      rd_sel = s_addr[0] ? rd_odd : rd_even;
   end

   // ------------------------------------------------------------
   // Bus access state machine
   // ------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      ack_n_d = ack_n_q;
      ack_oe_d = ack_oe_q;
      rd_d = rd_q;
      rd_oe_d = rd_oe_q;
      mem_d = mem_q;
      valid_d = valid_q;
      case (st_q)
         addr_recog_pkg::ST_IDLE:
         begin
            if (go_ok)
            begin
               st_d = addr_recog_pkg::ST_ACK;
               ack_n_d = 1'h0;
               ack_oe_d = 1'h1;
               if (s_rw)
               begin
                  rd_d = s_byte ? {rd_sel, rd_sel} : {rd_even, rd_odd};
                  rd_oe_d = 1'h1;
               end
               else
               begin
                  if (we_even)
                     mem_d[ent][{wrd, 4'h0} +: 8] = s_data[15:8];
                  if (we_odd)
                     mem_d[ent][{wrd, 4'h8} +: 8] = wr_odd;
                  if (!prot)
                     valid_d[ent] = wr_b5;
               end
            end
         end
         addr_recog_pkg::ST_ACK:
         begin
            if (s_as_n)
            begin
               st_d = addr_recog_pkg::ST_IDLE;
               ack_n_d = addr_recog_pkg::ACK_N_RESET;
               ack_oe_d = 1'h0;
               rd_oe_d = 1'h0;
            end
         end
         default:
         begin
            st_d = addr_recog_pkg::ST_IDLE;
            ack_n_d = addr_recog_pkg::ACK_N_RESET;
            ack_oe_d = 1'h0;
            rd_oe_d = 1'h0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Match lookup
   // ------------------------------------------------------------
   always_comb
   begin
      perf_hit = 1'h0;
      perf_idx = addr_recog_pkg::INDEX_RESET;
      for (int i = ENTRIES - 1; i >= 0; i--)
      begin
         if (valid_q[i] && !(hash_enable_in && i >= ENTRIES - addr_recog_pkg::HASH_ENTRIES) &&
             mem_q[i] == cmp_addr_in)
         begin
            perf_hit = 1'h1;
            perf_idx = 6'(i);
         end
      end
      hash_hit = hash_enable_in && mask_bit(cmp_crc_top_in);
      done_d = cmp_valid_in;
      perf_d = perf_q;
      hash_d = hash_q;
      idx_d = idx_q;
      if (cmp_valid_in)
      begin
         perf_d = perf_hit;
         hash_d = !perf_hit && hash_hit;
         idx_d = perf_hit ? perf_idx : cmp_crc_top_in;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         st_q <= addr_recog_pkg::ST_IDLE;
         ack_n_q <= addr_recog_pkg::ACK_N_RESET;
         ack_oe_q <= 1'h0;
         rd_q <= addr_recog_pkg::RD_DATA_RESET;
         rd_oe_q <= 1'h0;
         valid_q <= '0;
         done_q <= 1'h0;
         perf_q <= 1'h0;
         hash_q <= 1'h0;
         idx_q <= addr_recog_pkg::INDEX_RESET;
      end
      else if (ce_in)
      begin
         st_q <= st_d;
         ack_n_q <= ack_n_d;
         ack_oe_q <= ack_oe_d;
         rd_q <= rd_d;
         rd_oe_q <= rd_oe_d;
         valid_q <= valid_d;
         done_q <= done_d;
         perf_q <= perf_d;
         hash_q <= hash_d;
         idx_q <= idx_d;
      end
   end

   // Table contents are left undefined by reset
   always_ff @(posedge core_clk_in)
   begin
      if (ce_in)
         mem_q <= mem_d;
   end

   assign bus_data_out = rd_q;
   assign bus_data_oe_out = rd_oe_q;
   assign transfer_acknowledge_n_out = ack_n_q;
   assign transfer_acknowledge_oe_out = ack_oe_q;
   assign match_done_out = done_q;
   assign match_perfect_out = perf_q;
   assign match_hash_out = hash_q;
   assign match_index_out = idx_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);

   sequence s_bad_req;
      ce_in && st_q == addr_recog_pkg::ST_IDLE && req && hit && !loc_ok(ent, wrd, hash_enable_in);
   endsequence

   sequence s_ack_on;
      !transfer_acknowledge_n_out && transfer_acknowledge_oe_out;
   endsequence

   no_ack_hole_a: assert property (s_bad_req |=> transfer_acknowledge_n_out)
      else $error("hole acknowledged");
   hash_hole_a: assert property (ce_in && st_q == addr_recog_pkg::ST_IDLE && req && hit && prot &&
      wrd == addr_recog_pkg::WORD_LAST |=> transfer_acknowledge_n_out && !bus_data_oe_out)
      else $error("hash hole acknowledged");
   ack_cycle_a: assert property (go_ok |=> s_ack_on ##1 (s_ack_on or (!ce_in || $past(s_as_n))))
      else $error("acknowledge not held");
   ack_release_a: assert property (ce_in && st_q == addr_recog_pkg::ST_ACK && s_as_n
      |=> transfer_acknowledge_n_out && !transfer_acknowledge_oe_out && !bus_data_oe_out)
      else $error("acknowledge not released");
   entry_disable_a: assert property (go_ok && !s_rw && !wr_b5 && !prot |=> !valid_q[$past(ent)])
      else $error("partial entry still enabled");
   entry_enable_a: assert property (go_ok && !s_rw && wr_b5 && !prot |=> valid_q[$past(ent)])
      else $error("entry not enabled by last byte");
   mask_free_a: assert property (go_ok && !s_rw && prot |=> valid_q == $past(valid_q))
      else $error("mask write touched enables");
   byte_lane_a: assert property (go_ok && s_rw && s_byte |=> bus_data_oe_out && bus_data_out[15:8] == $past(rd_sel))
      else $error("byte read on wrong lane");
   perfect_wins_a: assert property (match_perfect_out |-> !match_hash_out)
      else $error("hash reported over perfect");
   hash_pick_a: assert property (ce_in && cmp_valid_in && !perf_hit && hash_enable_in
      |=> match_hash_out == $past(hash_hit) && match_index_out == $past(cmp_crc_top_in))
      else $error("hash index lookup wrong");

endmodule : addr_recog_table

//--- test/bus_master_model.sv
// Bus master model for the address-recognition table's handshake bus.
// Assumes the bench resolves the data and acknowledge wires and feeds them back here.
`timescale 1ns/1ps

module bus_master_model
(
   input wire logic core_clk_in,
   input wire logic [23:12] base_in,
   input wire logic ack_wire_in,
   input wire logic [15:0] data_wire_in,
   output logic [23:1] addr_out,
   output logic a0_out,
   output logic as_n_out,
   output logic uds_n_out,
   output logic lds_n_out,
   output logic rw_out,
   output logic byte_mode_out,
   output logic [15:0] data_out
);
   initial
   begin
      addr_out = '0;
      a0_out = 1'b0;
      as_n_out = 1'b1;
      uds_n_out = 1'b1;
      lds_n_out = 1'b1;
      rw_out = 1'b1;
      byte_mode_out = 1'b0;
      data_out = 16'h5a5a;
   end

   // ------------------------------------------------------------
   // One cycle: hold everything until acknowledge, give up after a bound
   // ------------------------------------------------------------
   task automatic access(input logic [11:0] off, input logic a0, input logic bm, input logic rw,
                         input logic [15:0] wd, output logic [15:0] rd, output logic acked);
      int n;
      acked = 1'b0;
      rd = '0;
      @(posedge core_clk_in);
      addr_out <= {base_in, off[11:1]};
      a0_out <= a0;
      byte_mode_out <= bm;
      rw_out <= rw;
      data_out <= rw ? ~data_out : wd;
      as_n_out <= 1'b0;
      uds_n_out <= 1'b0;
      lds_n_out <= bm;
      for (n = 0; n < 10 && !acked; n++)
      begin
         @(negedge core_clk_in);
         if (ack_wire_in === 1'b0)
         begin
            acked = 1'b1;
            rd = data_wire_in;
         end
      end
      // Missing acknowledge ends the cycle by timeout
      @(posedge core_clk_in);
      as_n_out <= 1'b1;
      uds_n_out <= 1'b1;
      lds_n_out <= 1'b1;
      // Released lines must not keep showing the last value
      data_out <= ~data_out;
      repeat (4) @(negedge core_clk_in);
   endtask : access
endmodule : bus_master_model

//--- test/mac_address_table_access_tb_top.sv
// Testbench for the address-recognition table: bus accesses and lookups.
// Assumes a pull-up on the acknowledge wire and a 10 MHz core clock.
`timescale 1ns/1ps

module mac_address_table_access_tb_top;
   logic core_clk_in, srst_in, hash_en, a0, as_n, uds_n, lds_n, rw, bm, d_oe, ack_n, ack_oe, ack_wire;
   logic cmp_valid, done, perf, hsh;
   logic [23:1] addr;
   logic [23:12] mbase;
   logic [15:0] m_data, d_out, d_wire;
   logic [47:0] cmp_addr;
   logic [5:0] crc, idx;
   int fail_count, cmp_count;
   localparam logic [47:0] ADDR_A = 48'hcba987654321;
   localparam logic [47:0] ADDR_B = 48'h0c0a08060402;

   assign d_wire = d_oe ? d_out : m_data;
   assign ack_wire = ack_oe ? ack_n : 1'b1;

   initial
   begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   addr_recog_table u_dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .ce_in(1'b1),
      .module_base_address_in(12'h123), .hash_enable_in(hash_en), .bus_addr_in(addr), .bus_a0_in(a0),
      .bus_as_n_in(as_n), .bus_uds_n_in(uds_n), .bus_lds_n_in(lds_n), .bus_rw_in(rw),
      .bus_byte_mode_in(bm), .bus_data_in(d_wire), .bus_data_out(d_out), .bus_data_oe_out(d_oe),
      .transfer_acknowledge_n_out(ack_n), .transfer_acknowledge_oe_out(ack_oe), .cmp_valid_in(cmp_valid),
      .cmp_addr_in(cmp_addr), .cmp_crc_top_in(crc), .match_done_out(done), .match_perfect_out(perf),
      .match_hash_out(hsh), .match_index_out(idx));

   bus_master_model u_master (.core_clk_in(core_clk_in), .base_in(mbase), .ack_wire_in(ack_wire),
      .data_wire_in(d_wire), .addr_out(addr), .a0_out(a0), .as_n_out(as_n), .uds_n_out(uds_n),
      .lds_n_out(lds_n), .rw_out(rw), .byte_mode_out(bm), .data_out(m_data));

   // ------------------------------------------------------------
   // Compare and access tasks
   // ------------------------------------------------------------
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {15'h0, exp}, {15'h0, got});
   endtask : chk_bit

   task automatic bus(input logic [11:0] off, input logic a0b, input logic bmb, input logic rwb,
                      input logic [15:0] wd, input logic exp_ack, input logic [15:0] exp_rd);
      logic [15:0] r;
      logic ok;
      u_master.access(off, a0b, bmb, rwb, wd, r, ok);
      chk_bit("acknowledge", exp_ack, ok);
      if (rwb && exp_ack)
         chk_word("read data", exp_rd, r);
   endtask : bus

   task automatic wr(input logic [11:0] off, input logic [15:0] d);
      bus(off, 1'b0, 1'b0, 1'b0, d, 1'b1, 16'h0);
   endtask : wr

   task automatic look(input logic [47:0] a, input logic [5:0] h, input logic ep, input logic eh,
                       input logic [5:0] ei);
      int n;
      logic seen;
      seen = 1'b0;
      @(posedge core_clk_in);
      cmp_valid <= 1'b1;
      cmp_addr <= a;
      crc <= h;
      @(posedge core_clk_in);
      cmp_valid <= 1'b0;
      for (n = 0; n < 4 && !seen; n++)
      begin
         @(negedge core_clk_in);
         seen = (done === 1'b1);
      end
      chk_bit("match done", 1'b1, seen);
      chk_bit("match perfect", ep, perf);
      if (eh !== 1'bx)
         chk_bit("match hash", eh, hsh);
      if (ep === 1'b1 || eh === 1'b1)
         chk_word("match index", {10'h0, ei}, {10'h0, idx});
      @(negedge core_clk_in);
      chk_bit("done pulse", 1'b0, done);
   endtask : look

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      fail_count = 0;
      cmp_count = 0;
      srst_in = 1'b1;
      hash_en = 1'b0;
      mbase = 12'h123;
      cmp_valid = 1'b0;
      cmp_addr = '0;
      crc = '0;
      repeat (20) @(posedge core_clk_in);
      srst_in <= 1'b0;
      @(negedge core_clk_in);
      chk_bit("ack enable after reset", 1'b0, ack_oe);
      chk_bit("data enable after reset", 1'b0, d_oe);
      wr(12'ha00, 16'h2143);
      wr(12'ha02, 16'h6587);
      wr(12'ha04, 16'ha9cb);
      look(ADDR_A, 6'h01, 1'b1, 1'b0, 6'h00);
      $display("test perfect entry done");
      wr(12'ha00, 16'h2143);
      look(ADDR_A, 6'h01, 1'b0, 1'b0, 6'h00);
      bus(12'ha04, 1'b0, 1'b1, 1'b0, 16'ha956, 1'b1, 16'h0);
      look(ADDR_A, 6'h01, 1'b0, 1'b0, 6'h00);
      bus(12'ha04, 1'b1, 1'b1, 1'b0, 16'hcb34, 1'b1, 16'h0);
      look(ADDR_A, 6'h01, 1'b1, 1'b0, 6'h00);
      $display("test partial write done");
      bus(12'ha04, 1'b0, 1'b0, 1'b1, 16'h0, 1'b1, 16'ha9cb);
      bus(12'ha02, 1'b1, 1'b1, 1'b1, 16'h0, 1'b1, 16'h8787);
      bus(12'ha00, 1'b0, 1'b1, 1'b1, 16'h0, 1'b1, 16'h2121);
      $display("test read back done");
      bus(12'ha06, 1'b0, 1'b0, 1'b1, 16'h0, 1'b0, 16'h0);
      bus(12'ha0e, 1'b0, 1'b0, 1'b0, 16'h1111, 1'b0, 16'h0);
      mbase = 12'h124;
      bus(12'ha00, 1'b0, 1'b0, 1'b1, 16'h0, 1'b0, 16'h0);
      mbase = 12'h123;
      $display("test unused locations done");
      wr(12'hbf0, 16'h0204);
      wr(12'hbf2, 16'h0608);
      wr(12'hbf4, 16'h0a0c);
      look(ADDR_B, 6'h05, 1'b1, 1'b0, 6'h3e);
      bus(12'hbf4, 1'b0, 1'b0, 1'b1, 16'h0, 1'b1, 16'h0a0c);
      $display("test last entries done");
      @(posedge core_clk_in);
      hash_en <= 1'b1;
      wr(12'hbfa, 16'h0001);
      wr(12'hbf2, 16'h0000);
      wr(12'hbf8, 16'h0000);
      wr(12'hbf0, 16'h8000);
      look(ADDR_B, 6'h05, 1'b0, 1'b0, 6'h00);
      look(ADDR_B, 6'h00, 1'b0, 1'b1, 6'h00);
      look(ADDR_B, 6'h3f, 1'b0, 1'b1, 6'h3f);
      look(ADDR_A, 6'h00, 1'b1, 1'b0, 6'h00);
      bus(12'hbf0, 1'b0, 1'b0, 1'b1, 16'h0, 1'b1, 16'h8000);
      bus(12'hbf4, 1'b0, 1'b0, 1'b1, 16'h0, 1'b0, 16'h0);
      bus(12'hbf6, 1'b0, 1'b0, 1'b0, 16'hffff, 1'b0, 16'h0);
      bus(12'hbfc, 1'b0, 1'b0, 1'b1, 16'h0, 1'b0, 16'h0);
      bus(12'hbfe, 1'b0, 1'b0, 1'b0, 16'hffff, 1'b0, 16'h0);
      look(ADDR_B, 6'h00, 1'b0, 1'b1, 6'h00);
      $display("test hash mode done");
      end_of_test();
   end
endmodule : mac_address_table_access_tb_top
